// *** rtl/timer16_compare.sv ***
/*
 16-bit timer with two compare channels behind an AHB-Lite slave.
 Assumes one clock hclk, asynchronous active-low hresetn, and that
 interrupt acknowledges come from logic on the same clock.
*/
// Contract
// RULE1: Compare counter with each channel every clock
// RULE2: Set compare flag on following timer tick
// RULE3: Enabled flag raises compare interrupt request
// RULE4: Service or written one clears compare flag
// RULE5: Drive outputs from match, mode and action
// RULE6: Give top and bottom to waveform logic (code passes only the top, at_top)
// RULE7: Channel A compare may define counter top
// RULE8: PWM buffers compare; other modes write directly
// RULE9: Copy buffered compare only at top
// RULE10: New action applies from next match
// RULE11: Force strobes act at once outside PWM
// RULE12: Only mode field steers counting
// RULE13: Action means polarity in PWM, else set/clear/toggle
// RULE14: Normal mode counts up, wraps, writable
// RULE15: Normal overflow flag set when count hits zero
// RULE16: Clear on channel A or capture match
// RULE17: Zero write keeps flags; count only on tick
// RULE18: Reset clears all state, outputs disconnected
`timescale 1ns/10ps
`default_nettype none
module timer16_compare
(
   input  wire logic        hclk,        // System clock
   input  wire logic        hresetn,     // Async reset, active low
   input  wire logic        hsel,        // Slave select
   input  wire logic [31:0] haddr,       // Byte address
   input  wire logic [1:0]  htrans,      // Transfer type
   input  wire logic        hwrite,      // Write when high
   input  wire logic [2:0]  hsize,       // Word only, unused
   input  wire logic [31:0] hwdata,      // Write data
   input  wire logic        hready,      // Bus ready
   output logic             hreadyout,   // Always ready
   output logic             hresp,       // Always OKAY
   output logic      [31:0] hrdata,      // Read data
   input  wire logic        irq_ack_a,   // Channel A serviced
   input  wire logic        irq_ack_b,   // Channel B serviced
   input  wire logic        irq_ack_ovf, // Overflow serviced
   output logic             irq_cmp_a,   // Channel A request
   output logic             irq_cmp_b,   // Channel B request
   output logic             irq_ovf,     // Overflow request
   output logic             cmp_out_a,   // Channel A pin level
   output logic             cmp_out_b,   // Channel B pin level
   output logic             cmp_oe_n_a,  // Low while A drives
   output logic             cmp_oe_n_b   // Low while B drives
);
   import timer16_pkg::*;

   typedef struct packed
   {
      logic [15:0] count;    // count_value
      logic [15:0] cmp_a;    // Active compare A
      logic [15:0] cmp_b;    // Active compare B
      logic [15:0] buf_a;    // Buffered compare A
      logic [15:0] buf_b;    // Buffered compare B
      logic [15:0] capt;     // capture_value_reg
      logic [3:0]  mode;     // waveform_mode_field
      logic [1:0]  act_a;    // Action channel A
      logic [1:0]  act_b;    // Action channel B
      logic [7:0]  pre;      // Divider terminal count
      logic [7:0]  div;      // Divider count
      logic [2:0]  flag;     // Match and overflow flags
      logic [2:0]  ien;      // Interrupt enables
      logic        out_a;    // Output A level
      logic        out_b;    // Output B level
      logic        dp_wr;    // Write data phase pending
      logic [7:0]  dp_addr;  // Latched address
      logic [31:0] rdata;    // Read data
   } state_t;

   state_t s;      // Current state
   state_t next_s; // Next state
   logic   tick;   // Timer clock enable
   logic   pwm;    // Mode is a PWM mode
   logic   at_top; // Counter at top
   logic   match_a;
   logic   match_b;
   logic   cnt_wr; // Software writes the counter
   logic [15:0] top;

   // PWM modes are all but normal, the two clear modes and reserved
   function automatic logic is_pwm(input logic [3:0] m);
      return !(m == MODE_NORMAL || m == MODE_CTC_A ||
               m == MODE_CTC_CAPT || m == MODE_RSVD);
   endfunction

   // Top value chosen by the mode
   function automatic logic [15:0] top_of(input logic [3:0] m,
      input logic [15:0] ca, input logic [15:0] cp);
      case (m)
         4'h1, 4'h5: return TOP_8BIT;
         4'h2, 4'h6: return TOP_9BIT;
         4'h3, 4'h7: return TOP_10BIT;
         4'h4, 4'h9, 4'hB, 4'hF: return ca;   // RULE16
         4'h8, 4'hA, 4'hC, 4'hE: return cp;   // RULE16
         default: return COUNT_MAX;
      endcase
   endfunction

   // Output level after a match, top or force
   function automatic logic wave(input logic [1:0] act,
      input logic cur, input logic hit, input logic tp,
      input logic pw);
      if (pw)
      begin
         // Polarity only: clear or set on match, opposite at top
         if (tp && act[1])
            return !act[0];
         if (hit && act[1])
            return act[0];
         return cur;
      end
      if (!hit)
         return cur;
      case (act)
         ACT_TOGGLE: return !cur;
         ACT_CLEAR:  return 1'b0;
         ACT_SET:    return 1'b1;
         default:    return cur;
      endcase
   endfunction

   // Register read mux, unmapped addresses read zero
   function automatic logic [31:0] rd(input state_t t,
      input logic [7:0] a);
      case (a)
         ADDR_CTRL:  return {16'h0000, t.pre, t.act_b, t.act_a,
                             t.mode};
         ADDR_COUNT: return {16'h0000, t.count};
         ADDR_CMP_A: return {16'h0000, t.buf_a};
         ADDR_CMP_B: return {16'h0000, t.buf_b};
         ADDR_CAPT:  return {16'h0000, t.capt};
         ADDR_FLAGS: return {29'h00000000, t.flag};
         ADDR_IEN:   return {29'h00000000, t.ien};
         default:    return 32'h00000000;
      endcase
   endfunction

   // Next state: divider, counter, flags, outputs and bus
   always_comb
   begin
      next_s  = s;
      tick    = (s.div == s.pre);                      // RULE17
      pwm     = is_pwm(s.mode);                        // RULE12
      top     = top_of(s.mode, s.cmp_a, s.capt);       // RULE7
      at_top  = (s.count == top);                      // RULE6
      match_a = (s.count == s.cmp_a);                  // RULE1
      match_b = (s.count == s.cmp_b);                  // RULE1
      cnt_wr  = s.dp_wr && (s.dp_addr == ADDR_COUNT);
      next_s.div = tick ? RST_PRE : s.div + 8'h01;
      // Clears first so that a same-cycle set wins
      if (irq_ack_a)
         next_s.flag[FLAG_A] = 1'b0;                   // RULE4
      if (irq_ack_b)
         next_s.flag[FLAG_B] = 1'b0;                   // RULE4
      if (irq_ack_ovf)
         next_s.flag[FLAG_OVF] = 1'b0;                 // RULE15
      if (s.dp_wr && s.dp_addr == ADDR_FLAGS)
         next_s.flag = next_s.flag & ~hwdata[2:0];     // RULE17
      if (tick)
      begin
         // Wrap at top; normal mode top is the largest count
         next_s.count = at_top ? COUNT_BOTTOM
                               : s.count + 16'h0001; // RULE14
         if (s.count == COUNT_MAX || (pwm && at_top))
            next_s.flag[FLAG_OVF] = 1'b1;              // RULE15
         if (match_a)
            next_s.flag[FLAG_A] = 1'b1;                // RULE2
         if (match_b)
            next_s.flag[FLAG_B] = 1'b1;                // RULE2
         next_s.out_a = wave(s.act_a, s.out_a, match_a,
                             at_top, pwm);             // RULE5
         next_s.out_b = wave(s.act_b, s.out_b, match_b,
                             at_top, pwm);             // RULE13
         if (pwm && at_top)
         begin
            next_s.cmp_a = s.buf_a;                    // RULE9
            next_s.cmp_b = s.buf_b;                    // RULE9
         end
      end
      // Data phase writes; software count write beats the tick
      if (s.dp_wr)
      begin
         case (s.dp_addr)
            ADDR_CTRL:
            begin
               next_s.mode  = hwdata[CTRL_MODE_LSB +: 4];
               next_s.act_a = hwdata[CTRL_ACT_A_LSB +: 2];  // RULE10
               next_s.act_b = hwdata[CTRL_ACT_B_LSB +: 2];
               next_s.pre   = hwdata[CTRL_PRE_LSB +: 8];
            end
            ADDR_COUNT: next_s.count = hwdata[15:0];   // RULE14
            ADDR_CMP_A:
            begin
               next_s.buf_a = hwdata[15:0];
               if (!pwm)
                  next_s.cmp_a = hwdata[15:0];         // RULE8
            end
            ADDR_CMP_B:
            begin
               next_s.buf_b = hwdata[15:0];
               if (!pwm)
                  next_s.cmp_b = hwdata[15:0];         // RULE8
            end
            ADDR_CAPT: next_s.capt = hwdata[15:0];
            ADDR_IEN:  next_s.ien  = hwdata[2:0];
            ADDR_FORCE:
            begin
               // Forced match: no flag, no counter clear
               if (!pwm && hwdata[0])
                  next_s.out_a = wave(s.act_a, s.out_a, 1'b1,
                                      1'b0, 1'b0);     // RULE11
               if (!pwm && hwdata[1])
                  next_s.out_b = wave(s.act_b, s.out_b, 1'b1,
                                      1'b0, 1'b0);     // RULE11
            end
            default: ;
         endcase
      end
      // Address phase: latch write, capture read data
      next_s.dp_wr   = hsel && hready && htrans[HTRANS_ACTIVE] &&
                       hwrite;
      next_s.dp_addr = haddr[7:0];
      if (hsel && hready && htrans[HTRANS_ACTIVE] && !hwrite)
         next_s.rdata = rd(s, haddr[7:0]);
   end

   // State register, cleared under reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s <= '0;                                      // RULE18
      else
         s <= next_s;
   end

   // Outputs
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign hrdata     = s.rdata;
   assign irq_cmp_a  = s.flag[FLAG_A] && s.ien[FLAG_A];     // RULE3
   assign irq_cmp_b  = s.flag[FLAG_B] && s.ien[FLAG_B];     // RULE3
   assign irq_ovf    = s.flag[FLAG_OVF] && s.ien[FLAG_OVF];
   assign cmp_out_a  = s.out_a;
   assign cmp_out_b  = s.out_b;
   assign cmp_oe_n_a = (s.act_a == ACT_OFF);                // RULE18
   assign cmp_oe_n_b = (s.act_b == ACT_OFF);

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Rule checks on counter, flags and pins
   AST_FLAG_AFTER_MATCH: assert property ( // RULE2
      tick && match_a |=> s.flag[FLAG_A])
      else $error("flag A not set after match");
   AST_IRQ_FOLLOWS_FLAG: assert property ( // RULE3
      tick && match_a |=> irq_cmp_a == s.ien[FLAG_A])
      else $error("irq A does not follow match and enable");
   AST_ACK_CLEARS: assert property ( // RULE4
      irq_ack_a && !(tick && match_a) |=> !s.flag[FLAG_A])
      else $error("ack did not clear flag A");
   AST_NORMAL_UP: assert property ( // RULE14
      tick && s.mode == MODE_NORMAL && !cnt_wr
      |=> s.count == $past(s.count) + 16'h0001)
      else $error("normal count did not step");
   AST_OVF_AT_ZERO: assert property ( // RULE15
      tick && s.mode == MODE_NORMAL && s.count == COUNT_MAX &&
      !cnt_wr |=> s.count == COUNT_BOTTOM && s.flag[FLAG_OVF])
      else $error("wrap without overflow flag");
   AST_CTC_CLEAR: assert property ( // RULE16
      tick && s.mode == MODE_CTC_A && match_a && !cnt_wr
      |=> s.count == COUNT_BOTTOM)
      else $error("clear mode did not clear");
   AST_HOLD_NO_TICK: assert property ( // RULE17
      !tick && !cnt_wr |=> $stable(s.count))
      else $error("count moved without tick");
   AST_FORCE_TOGGLE: assert property ( // RULE11
      s.dp_wr && s.dp_addr == ADDR_FORCE && hwdata[0] && !pwm &&
      s.act_a == ACT_TOGGLE |=> cmp_out_a != $past(cmp_out_a))
      else $error("force did not toggle A");
   AST_DIRECT_WRITE: assert property ( // RULE8
      s.dp_wr && s.dp_addr == ADDR_CMP_A && !pwm
      |=> s.cmp_a == $past(hwdata[15:0]))
      else $error("compare A not written directly");
   AST_BUFFER_HOLD: assert property ( // RULE9
      pwm && !(tick && at_top) |=> $stable(s.cmp_a))
      else $error("buffered compare moved off top");
   AST_SET_ON_MATCH: assert property ( // RULE13
      tick && match_b && !pwm && s.act_b == ACT_SET &&
      !(s.dp_wr && s.dp_addr == ADDR_FORCE) |=> cmp_out_b)
      else $error("set action did not set B");

   // Scenarios the bench should reach
   COV_CTC: cover property (tick && s.mode == MODE_CTC_A && match_a);
   COV_OVF: cover property ($rose(irq_ovf));
   COV_FORCE: cover property (s.dp_wr && s.dp_addr == ADDR_FORCE);
   COV_PWM_TOP: cover property (pwm && tick && at_top);
endmodule
`default_nettype wire

// *** rtl/timer16_pkg.sv ***
/*
 Constants for the 16-bit two-channel compare timer: register map,
 field positions, reset values, mode and action codes.
 Assumes an AHB-Lite bus with 32-bit data and word-aligned registers.
*/
package timer16_pkg;
   // Byte addresses of the registers
   localparam logic [7:0] ADDR_CTRL  = 8'h00; // Mode, actions, divider
   localparam logic [7:0] ADDR_COUNT = 8'h04; // count_value
   localparam logic [7:0] ADDR_CMP_A = 8'h08; // compare_value_a
   localparam logic [7:0] ADDR_CMP_B = 8'h0C; // Channel B compare
   localparam logic [7:0] ADDR_CAPT  = 8'h10; // capture_value_reg
   localparam logic [7:0] ADDR_FLAGS = 8'h14; // Flags, write one clears
   localparam logic [7:0] ADDR_IEN   = 8'h18; // Interrupt enables
   localparam logic [7:0] ADDR_FORCE = 8'h1C; // Force strobes, read 0
   // Control field positions
   localparam int CTRL_MODE_LSB  = 0;  // waveform_mode_field, 4 bits
   localparam int CTRL_ACT_A_LSB = 4;  // Channel A action, 2 bits
   localparam int CTRL_ACT_B_LSB = 6;  // Channel B action, 2 bits
   localparam int CTRL_PRE_LSB   = 8;  // Tick divider, 8 bits
   // Flag and enable bit positions
   localparam int FLAG_A   = 0;        // Channel A match
   localparam int FLAG_B   = 1;        // Channel B match
   localparam int FLAG_OVF = 2;        // Overflow
   // Mode codes
   localparam logic [3:0] MODE_NORMAL   = 4'h0; // Free running
   localparam logic [3:0] MODE_CTC_A    = 4'h4; // Clear on channel A
   localparam logic [3:0] MODE_CTC_CAPT = 4'hC; // Clear on capture reg
   localparam logic [3:0] MODE_RSVD     = 4'hD; // Reserved, no PWM
   // compare_output_action codes
   localparam logic [1:0] ACT_OFF    = 2'h0; // Pin disconnected
   localparam logic [1:0] ACT_TOGGLE = 2'h1; // Toggle on match
   localparam logic [1:0] ACT_CLEAR  = 2'h2; // Clear on match
   localparam logic [1:0] ACT_SET    = 2'h3; // Set on match
   // Counter limits
   localparam logic [15:0] COUNT_MAX    = 16'hFFFF; // Largest value
   localparam logic [15:0] COUNT_BOTTOM = 16'h0000; // Smallest value
   localparam logic [15:0] TOP_8BIT     = 16'h00FF; // Fixed tops
   localparam logic [15:0] TOP_9BIT     = 16'h01FF;
   localparam logic [15:0] TOP_10BIT    = 16'h03FF;
   // Reset values
   localparam logic [15:0] RST_WORD = 16'h0000; // Count, compares
   localparam logic [7:0]  RST_PRE  = 8'h00;    // Tick every cycle
   localparam logic [2:0]  RST_BITS = 3'h0;     // Flags, enables
   // AHB transfer type bit that marks an active transfer
   localparam int HTRANS_ACTIVE = 1;
endpackage

// *** testbench/timer16_compare_normal_ctc_bench.sv ***
/*
 Self-checking bench for the two-channel 16-bit compare timer.
 Assumes the design answers with zero wait states and the package map.
*/
`timescale 1ns/10ps
`default_nettype none
module timer16_compare_normal_ctc_bench;
   import timer16_pkg::*;
   logic        hclk, hresetn, hsel, hwrite;  // Clock, reset, bus control
   logic [31:0] haddr, hwdata;                // Address and write data
   logic [1:0]  htrans;                       // Transfer type
   logic [2:0]  hsize;                        // Always word
   logic        irq_ack_a, irq_ack_b, irq_ack_ovf; // Service pulses
   wire  logic  hready, hresp;                // Bus ready and response
   wire  logic [31:0] hrdata;                 // Read data
   wire  logic  irq_cmp_a, irq_cmp_b, irq_ovf; // Requests
   wire  logic  cmp_out_a, cmp_out_b, cmp_oe_n_a, cmp_oe_n_b; // Pins
   int          n_errors, check_count;        // Tallies
   logic [31:0] rd;                           // Last read word
   timer16_compare i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .irq_ack_a(irq_ack_a), .irq_ack_b(irq_ack_b),
      .irq_ack_ovf(irq_ack_ovf), .irq_cmp_a(irq_cmp_a),
      .irq_cmp_b(irq_cmp_b), .irq_ovf(irq_ovf), .cmp_out_a(cmp_out_a),
      .cmp_out_b(cmp_out_b), .cmp_oe_n_a(cmp_oe_n_a),
      .cmp_oe_n_b(cmp_oe_n_b));
   // Clock generator
   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   // Compare and report
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task automatic wrap_up;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // One AHB transfer; read data taken at the data-phase edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      #1;
   endtask
   // Control word builder
   function automatic logic [31:0] ctrl(input logic [3:0] m,
      input logic [1:0] aa, input logic [1:0] ab, input logic [7:0] p);
      return {16'h0000, p, ab, aa, m};
   endfunction
   // Poll a flag until it sets, bounded
   task automatic wait_flag(input int idx);
      int i;
      for (i = 0; i < 300; i++)
      begin
         bus(1'b0, ADDR_FLAGS, 32'h0);
         if (rd[idx] === 1'b1) break;
      end
      check({31'h0, rd[idx]}, 32'h1);
   endtask
   // One service pulse on the chosen acknowledge
   task automatic ack(input int idx);
      @(posedge hclk);
      {irq_ack_ovf, irq_ack_b, irq_ack_a} <= 3'h1 << idx;
      @(posedge hclk);
      {irq_ack_ovf, irq_ack_b, irq_ack_a} <= 3'h0;
   endtask
   // Reset state of pins and registers, unmapped read
   task automatic t_reset;
      check({hresp, irq_cmp_a, irq_cmp_b, irq_ovf}, 32'h0);
      check({cmp_out_a, cmp_out_b, cmp_oe_n_a, cmp_oe_n_b}, 32'h3);
      bus(1'b0, ADDR_CTRL, 32'h0);
      check(rd, 32'h0);
      bus(1'b0, ADDR_CMP_A, 32'h0);
      check(rd, 32'h0);
      // Count and both compares sit at zero, so both match flags rise
      bus(1'b0, ADDR_FLAGS, 32'h0);
      check(rd, 32'h3);
      bus(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0);
   endtask
   // Normal mode wrap, overflow flag, zero write, service clear
   task automatic t_overflow;
      bus(1'b1, ADDR_IEN, 32'h4);
      bus(1'b1, ADDR_COUNT, 32'hFFF0);
      bus(1'b0, ADDR_COUNT, 32'h0);
      check({31'h0, (rd - 32'hFFF0) < 32'h8}, 32'h1);
      bus(1'b0, ADDR_FLAGS, 32'h0);
      check({31'h0, rd[FLAG_OVF]}, 32'h0);
      wait_flag(FLAG_OVF);
      bus(1'b0, ADDR_COUNT, 32'h0);
      check({31'h0, rd < 32'h20}, 32'h1);
      check({31'h0, irq_ovf}, 32'h1);
      bus(1'b1, ADDR_FLAGS, 32'h0);
      bus(1'b0, ADDR_FLAGS, 32'h0);
      check({31'h0, rd[FLAG_OVF]}, 32'h1);
      ack(FLAG_OVF);
      bus(1'b0, ADDR_FLAGS, 32'h0);
      check({31'h0, rd[FLAG_OVF]}, 32'h0);
   endtask
   // Matches on both channels, actions, requests and clearing
   task automatic t_match;
      bus(1'b1, ADDR_CMP_A, 32'h0040);
      bus(1'b1, ADDR_CMP_B, 32'h0080);
      bus(1'b1, ADDR_CTRL, ctrl(MODE_NORMAL, ACT_TOGGLE, ACT_SET, 8'h00));
      bus(1'b1, ADDR_IEN, 32'h3);
      bus(1'b1, ADDR_FLAGS, 32'h7);
      bus(1'b1, ADDR_COUNT, 32'h0);
      check({cmp_oe_n_a, cmp_oe_n_b, cmp_out_a, cmp_out_b}, 32'h0);
      wait_flag(FLAG_A);
      check({cmp_out_a, cmp_out_b}, 32'h2);
      check({31'h0, irq_cmp_a}, 32'h1);
      ack(FLAG_A);
      bus(1'b0, ADDR_FLAGS, 32'h0);
      check({31'h0, rd[FLAG_A]}, 32'h0);
      wait_flag(FLAG_B);
      check({cmp_out_a, cmp_out_b, irq_cmp_b}, 32'h7);
      bus(1'b1, ADDR_FLAGS, 32'h2);
      bus(1'b0, ADDR_FLAGS, 32'h0);
      check({30'h0, rd[1:0]}, 32'h0);
   endtask
   // Force strobes act at once and set no flag
   task automatic t_force;
      bus(1'b1, ADDR_CMP_A, 32'hFFF0);
      bus(1'b1, ADDR_CMP_B, 32'hFFF0);
      bus(1'b1, ADDR_CTRL, ctrl(MODE_NORMAL, ACT_TOGGLE, ACT_CLEAR, 8'h00));
      bus(1'b1, ADDR_FORCE, 32'h3);
      check({cmp_out_a, cmp_out_b}, 32'h0);
      bus(1'b0, ADDR_FORCE, 32'h0);
      check(rd, 32'h0);
      bus(1'b0, ADDR_FLAGS, 32'h0);
      check(rd, 32'h0);
   endtask
   // Clear on compare against channel A or the capture register
   task automatic t_ctc(input logic [3:0] m, input logic [15:0] top);
      logic [31:0] mx;
      mx = 32'h0;
      bus(1'b1, ADDR_CMP_A, 32'h0010);
      bus(1'b1, ADDR_CAPT, 32'h000A);
      bus(1'b1, ADDR_CTRL, ctrl(m, ACT_OFF, ACT_OFF, 8'h00));
      bus(1'b1, ADDR_COUNT, 32'h0);
      repeat (60)
      begin
         bus(1'b0, ADDR_COUNT, 32'h0);
         if (rd > mx) mx = rd;
      end
      check(mx, {16'h0000, top});
   endtask
   // Count advances only on divider ticks
   task automatic t_tick;
      bus(1'b1, ADDR_CTRL, ctrl(MODE_NORMAL, ACT_OFF, ACT_OFF, 8'h03));
      bus(1'b1, ADDR_COUNT, 32'h0);
      repeat (40) @(posedge hclk);
      bus(1'b0, ADDR_COUNT, 32'h0);
      check({31'h0, rd >= 32'hA && rd <= 32'hC}, 32'h1);
   endtask
   // PWM with capture top: compare A waits in its buffer until top
   task automatic t_pwm;
      bus(1'b1, ADDR_CMP_A, 32'h0030);
      bus(1'b1, ADDR_CAPT, 32'h0040);
      bus(1'b1, ADDR_CTRL, ctrl(4'hE, ACT_CLEAR, ACT_OFF, 8'h00));
      bus(1'b1, ADDR_COUNT, 32'h0);
      bus(1'b1, ADDR_CMP_A, 32'h0010);
      bus(1'b1, ADDR_FLAGS, 32'h7);
      // Old compare still active: first match near 0x30
      wait_flag(FLAG_A);
      bus(1'b0, ADDR_COUNT, 32'h0);
      check({31'h0, rd >= 32'h30 && rd < 32'h40}, 32'h1);
      bus(1'b1, ADDR_FLAGS, 32'h1);
      // Buffered value copied at top: next match near 0x10
      wait_flag(FLAG_A);
      bus(1'b0, ADDR_COUNT, 32'h0);
      check({31'h0, rd >= 32'h10 && rd < 32'h20}, 32'h1);
   endtask
   // Main sequence
   initial
   begin
      n_errors = 0;
      check_count = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      irq_ack_a = 1'b0;
      irq_ack_b = 1'b0;
      irq_ack_ovf = 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      t_reset;
      t_overflow;
      t_match;
      t_force;
      t_ctc(MODE_CTC_A, 16'h0010);
      t_ctc(MODE_CTC_CAPT, 16'h000A);
      t_tick;
      t_pwm;
      wrap_up;
   end
   // Watchdog against a hung bus that never returns ready
   initial
   begin
      #400000;
      n_errors++;
      wrap_up;
   end
endmodule
`default_nettype wire
